// ### nct_cfg.svh
// Constants for the charge-phase sequencer: offsets, fields, resets and timing counts
`ifndef NCT_CFG_SVH
`define NCT_CFG_SVH

// ==========================================================================
// Time base
`define NCT_CLK_HZ          20000000
`define NCT_TICK_MS         125
`define NCT_TICK_CYCLES     (`NCT_TICK_MS * (`NCT_CLK_HZ / 1000))
`define NCT_TICKS_PER_MIN   (60000 / `NCT_TICK_MS)
`define NCT_PRECHARGE_MIN   30
`define NCT_PRECHARGE_TICKS (`NCT_PRECHARGE_MIN * `NCT_TICKS_PER_MIN)
`define NCT_BLANK_DECIMIN   43
`define NCT_BLANK_TICKS     ((`NCT_BLANK_DECIMIN * `NCT_TICKS_PER_MIN) / 10)
`define NCT_DECIMIN_PER_KOHM 15
`define NCT_TICKS_PER_KOHM  ((`NCT_DECIMIN_PER_KOHM * `NCT_TICKS_PER_MIN) / 10)

// ==========================================================================
// Temperature-rate step: thermistor codes per minute for 0.5 C rise
`define NCT_TERM_CODES      10'h005

// ==========================================================================
// Register map
`define NCT_CTRL_OFFS       12'h000
`define NCT_STATUS_OFFS     12'h004
`define NCT_TIMER_OFFS      12'h008
`define NCT_KOHM_RESET      8'h2F
`define NCT_CTRL_KOHM_LSB   0
`define NCT_CTRL_QUARTER    8
`define NCT_STAT_DRIVE      8
`define NCT_STAT_IND        9
`define NCT_STAT_RATE       10
`define NCT_STAT_ARMED      11

`endif

// ### nct_pkg.sv
// Types shared by the charge-phase sequencer files
package nct_pkg;

  // ==========================================================================
  // Charge phases, one-hot
  typedef enum logic [5:0] {
    NCT_IDLE      = 6'b00_0001,
    NCT_PRECHARGE = 6'b00_0010,
    NCT_FAST      = 6'b00_0100,
    NCT_TOPOFF    = 6'b00_1000,
    NCT_DONE      = 6'b01_0000,
    NCT_FAULT     = 6'b10_0000
  } nct_state_e;

  // ==========================================================================
  // Synchronised comparator and threshold results from the analog front end
  typedef struct packed {
    logic sense_at_low;        // Sense voltage crossed the low threshold
    logic sense_at_high;       // Sense voltage crossed the high threshold
    logic below_cold_limit;    // Thermistor below cold_limit_threshold
    logic above_warm_limit;    // Thermistor above warm_limit_threshold
    logic at_overheat_stop;    // Thermistor at overheat_stop_threshold
    logic cell_above_low;      // Cell above low_cell_threshold
    logic pack_open;           // Cell pack removed
    logic timer_pin_float;     // timer_resistor_pin left floating
    logic mode_comparator;     // Mode input tied to the bias reference
  } nct_sense_s;

  typedef logic [17:0] nct_timer_t;

endpackage : nct_pkg

// ### nct_tick_gen.sv
// Prescaler: base tick, minute enable and indicator blink phases
`timescale 1ns/1ps
`include "nct_cfg.svh"

module nct_tick_gen #(
  parameter int unsigned TICK_CYCLES = `NCT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Enables and blink phases
  output logic      tick_en,
  output logic      minute_en,
  output logic      blink_fast,
  output logic      blink_slow
);
  import nct_pkg::*;

  logic [21:0] div_reg, div_next;
  logic [8:0]  min_reg, min_next;
  logic [2:0]  blk_reg, blk_next;

  // ==========================================================================
  // Dividers
  always_comb begin
    tick_en   = (div_reg == 22'(TICK_CYCLES - 1));
    minute_en = tick_en && (min_reg == 9'(`NCT_TICKS_PER_MIN - 1));
    div_next  = tick_en ? 22'h00_0000 : div_reg + 22'h00_0001;
    min_next  = min_reg;
    blk_next  = blk_reg;
    if (tick_en) begin
      min_next = minute_en ? 9'h000 : min_reg + 9'h001;
      blk_next = blk_reg + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_reg <= 22'h00_0000;
      min_reg <= 9'h000;
      blk_reg <= 3'h0;
    end else begin
      div_reg <= div_next;
      min_reg <= min_next;
      blk_reg <= blk_next;
    end
  end

  // 125 ms per half period gives 4 Hz, four ticks per half gives 1 Hz
  assign blink_fast = blk_reg[0];
  assign blink_slow = blk_reg[2];

endmodule : nct_tick_gen

// ### nct_rate_detect.sv
// Temperature-rate detector on the digitised thermistor voltage
`timescale 1ns/1ps
`include "nct_cfg.svh"

module nct_rate_detect (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Control
  input  wire logic       arm,
  input  wire logic       minute_en,
  input  wire logic [9:0] thm_code,
  // Result
  output logic            trip
);
  import nct_pkg::*;

  logic [9:0] ref_reg, ref_next;
  logic       valid_reg, valid_next;
  logic       trip_reg, trip_next;
  logic [9:0] drop;

  // ==========================================================================
  // Minute-to-minute comparison; NTC voltage falls as the cell warms
  always_comb begin
    drop       = ref_reg - thm_code;
    ref_next   = ref_reg;
    valid_next = valid_reg;
    trip_next  = trip_reg;
    if (!arm) begin
      valid_next = 1'b0;
      trip_next  = 1'b0;
    end else if (minute_en) begin
      ref_next   = thm_code;
      valid_next = 1'b1;
      if (valid_reg && (ref_reg > thm_code) && (drop > `NCT_TERM_CODES)) begin
        trip_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ref_reg   <= 10'h000;
      valid_reg <= 1'b0;
      trip_reg  <= 1'b0;
    end else begin
      ref_reg   <= ref_next;
      valid_reg <= valid_next;
      trip_reg  <= trip_next;
    end
  end

  assign trip = trip_reg;

endmodule : nct_rate_detect

// ### nct_charge_seq.sv
// Charge-phase sequencer with phase timers, thermal limits and APB registers
// ==========================================================================
// Summary of operation
// - Comparator mode: drive on at low sense threshold, off at high threshold.
// - Averages near -0.107 V fast, -0.029 V top-off; reference select per phase.
// - Mode input tied to bias reference selects comparator regulation, else linear.
// - Precharge limited to 30 minutes from the tick; overrun faults.
// - Fast-charge ends on temperature rate; safety timeout is the backup.
// - Safety timeout in fast-charge clears the timer and enters top-off.
// - Top-off limit is half the fast limit, or a quarter for the variant.
// - Timer expiry in top-off enters done.
// - Fast limit is 1.5 minutes per kilohm, 0.5 to 6 hours; the 8-bit kilohm field allows 0 to 382.5 minutes.
// - Charging starts only with thermistor inside the cold and warm limits.
// - Overheat stop threshold during precharge halts it and faults.
// - Overheat stop threshold during fast-charge or top-off enters done.
// - Temperature-rate trip in fast-charge moves to top-off.
// - Floating timer resistor pin suspends and resets the state machine.
// - Rate trip declared above 0.5 C per minute rise.
// - Rate trip ignored for 4.3 minutes after fast-charge begins.
// - Indicator pulses low 1 Hz charging, 4 Hz fault, else released.
// - Precharge faults if cell not above 1.0 V by timeout; fault releases drive.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "nct_cfg.svh"

module nct_charge_seq #(
  parameter int unsigned TICK_CYCLES = `NCT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Analog front end
  input  wire nct_pkg::nct_sense_s sense_in,
  input  wire logic [9:0]         thm_code,
  output logic                    ref_topoff,
  // Open-drain charge drive
  output logic                    charge_drive_out,
  output logic                    charge_drive_oe,
  // Open-drain status indicator
  output logic                    status_indicator_out,
  output logic                    status_indicator_oe
);
  import nct_pkg::*;

  // ==========================================================================
  // Declarations
  nct_state_e state_reg, state_next;
  nct_timer_t timer_reg, timer_next;
  logic       drive_on_reg, drive_on_next;
  logic       drive_oe_reg, drive_oe_next;
  logic       ind_oe_reg, ind_oe_next;
  logic       ref_to_reg, ref_to_next;
  logic [7:0] kohm_reg, kohm_next;
  logic       quarter_reg, quarter_next;
  logic [31:0] prdata_reg, prdata_next;
  logic       tick_en;
  logic       minute_en;
  logic       blink_fast;
  logic       blink_slow;
  logic       rate_trip;
  logic       rate_arm;
  logic       expired;
  logic       charging;
  logic       wr_en;
  logic       rd_setup;
  logic       mapped;

  // ==========================================================================
  // Phase limit in ticks for a given phase
  function automatic nct_timer_t phase_limit(input nct_state_e st,
                                             input logic [7:0] kohm,
                                             input logic       quarter);
    nct_timer_t fast_lim;
    fast_lim = 18'(kohm) * 18'(`NCT_TICKS_PER_KOHM);
    unique case (st)
      NCT_PRECHARGE: phase_limit = 18'(`NCT_PRECHARGE_TICKS);
      NCT_FAST:      phase_limit = fast_lim;
      NCT_TOPOFF:    phase_limit = quarter ? (fast_lim >> 2) : (fast_lim >> 1);
      default:       phase_limit = 18'h3_FFFF;
    endcase
  endfunction : phase_limit

  // ==========================================================================
  // Time base and rate detector
  nct_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk        (clk),
    .reset_n    (reset_n),
    .tick_en    (tick_en),
    .minute_en  (minute_en),
    .blink_fast (blink_fast),
    .blink_slow (blink_slow)
  );

  // Charge initiation warms the thermistor, so the detector waits out the blank
  assign rate_arm = (state_reg == NCT_FAST) &&
                    (timer_reg >= 18'(`NCT_BLANK_TICKS));

  nct_rate_detect u_rate (
    .clk       (clk),
    .reset_n   (reset_n),
    .arm       (rate_arm),
    .minute_en (minute_en),
    .thm_code  (thm_code),
    .trip      (rate_trip)
  );

  // ==========================================================================
  // Phase sequencer
  assign expired  = tick_en &&
                    ((timer_reg + 18'h0_0001) >= phase_limit(state_reg, kohm_reg, quarter_reg));
  assign charging = (state_reg == NCT_PRECHARGE) || (state_reg == NCT_FAST) ||
                    (state_reg == NCT_TOPOFF);

  always_comb begin
    state_next = state_reg;
    timer_next = (tick_en && charging) ? timer_reg + 18'h0_0001 : timer_reg;
    unique case (state_reg)
      NCT_IDLE: begin
        if (sense_in.below_cold_limit && sense_in.above_warm_limit) begin
          state_next = NCT_PRECHARGE;
        end
      end
      NCT_PRECHARGE: begin
        if (sense_in.at_overheat_stop) begin
          state_next = NCT_FAULT;
        end else if (sense_in.cell_above_low) begin
          state_next = NCT_FAST;
        end else if (expired) begin
          state_next = NCT_FAULT;
        end
      end
      NCT_FAST: begin
        if (sense_in.at_overheat_stop) begin
          state_next = NCT_DONE;
        end else if (rate_trip) begin
          state_next = NCT_TOPOFF;
        end else if (expired) begin
          state_next = NCT_TOPOFF;
        end
      end
      NCT_TOPOFF: begin
        if (sense_in.at_overheat_stop) begin
          state_next = NCT_DONE;
        end else if (expired) begin
          state_next = NCT_DONE;
        end
      end
      NCT_DONE, NCT_FAULT: begin
        if (sense_in.pack_open) begin
          state_next = NCT_IDLE;
        end
      end
      default: state_next = NCT_IDLE;
    endcase
    if (sense_in.timer_pin_float) begin
      state_next = NCT_IDLE;
    end
    if (state_next != state_reg) begin
      timer_next = 18'h0_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= NCT_IDLE;
      timer_reg <= 18'h0_0000;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // ==========================================================================
  // Charge drive and indicator
  always_comb begin
    drive_on_next = drive_on_reg;
    if (!charging) begin
      drive_on_next = 1'b0;
    end else if (sense_in.sense_at_high) begin
      drive_on_next = 1'b0;
    end else if (sense_in.sense_at_low) begin
      drive_on_next = 1'b1;
    end
    // Linear mode leaves regulation to the amplifier; the pin just sinks while charging
    if (!charging) begin
      drive_oe_next = 1'b0;
    end else if (sense_in.mode_comparator) begin
      drive_oe_next = drive_on_next;
    end else begin
      drive_oe_next = 1'b1;
    end
    ref_to_next = (state_next != NCT_FAST);
    ind_oe_next = (charging && blink_slow) ||
                  ((state_reg == NCT_FAULT) && blink_fast);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drive_on_reg <= 1'b0;
      drive_oe_reg <= 1'b0;
      ind_oe_reg   <= 1'b0;
      ref_to_reg   <= 1'b1;
    end else begin
      drive_on_reg <= drive_on_next;
      drive_oe_reg <= drive_oe_next;
      ind_oe_reg   <= ind_oe_next;
      ref_to_reg   <= ref_to_next;
    end
  end

  assign charge_drive_out     = 1'b0;
  assign charge_drive_oe      = drive_oe_reg;
  assign status_indicator_out = 1'b0;
  assign status_indicator_oe  = ind_oe_reg;
  assign ref_topoff           = ref_to_reg;

  // ==========================================================================
  // APB registers: zero wait states, read data captured in the setup cycle
  assign mapped   = (paddr == `NCT_CTRL_OFFS) || (paddr == `NCT_STATUS_OFFS) ||
                    (paddr == `NCT_TIMER_OFFS);
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_reg;

  always_comb begin
    kohm_next    = kohm_reg;
    quarter_next = quarter_reg;
    prdata_next  = prdata_reg;
    if (wr_en && (paddr == `NCT_CTRL_OFFS)) begin
      kohm_next    = pwdata[`NCT_CTRL_KOHM_LSB +: 8];
      quarter_next = pwdata[`NCT_CTRL_QUARTER];
    end
    if (rd_setup) begin
      prdata_next = 32'h0000_0000;
      if (paddr == `NCT_CTRL_OFFS) begin
        prdata_next[`NCT_CTRL_KOHM_LSB +: 8] = kohm_reg;
        prdata_next[`NCT_CTRL_QUARTER]       = quarter_reg;
      end else if (paddr == `NCT_STATUS_OFFS) begin
        prdata_next[5:0]             = state_reg;
        prdata_next[`NCT_STAT_DRIVE] = drive_oe_reg;
        prdata_next[`NCT_STAT_IND]   = ind_oe_reg;
        prdata_next[`NCT_STAT_RATE]  = rate_trip;
        prdata_next[`NCT_STAT_ARMED] = rate_arm;
      end else if (paddr == `NCT_TIMER_OFFS) begin
        prdata_next[17:0] = timer_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      kohm_reg    <= `NCT_KOHM_RESET;
      quarter_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      kohm_reg    <= kohm_next;
      quarter_reg <= quarter_next;
      prdata_reg  <= prdata_next;
    end
  end

endmodule : nct_charge_seq

// ### nct_charge_seq_chk.sv
// Port checker for the charge-phase sequencer
`timescale 1ns/1ps
`include "nct_cfg.svh"

module nct_charge_seq_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                reset_n,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Front end and pins
  input wire nct_pkg::nct_sense_s sense_in,
  input wire logic [9:0]          thm_code,
  input wire logic                ref_topoff,
  input wire logic                charge_drive_out,
  input wire logic                charge_drive_oe,
  input wire logic                status_indicator_out,
  input wire logic                status_indicator_oe
);
  import nct_pkg::*;
  logic unmapped;
  logic window;
  assign unmapped = !(paddr inside {`NCT_CTRL_OFFS, `NCT_STATUS_OFFS, `NCT_TIMER_OFFS});
  assign window = sense_in.below_cold_limit && sense_in.above_warm_limit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Sequences
  sequence access_s;
    psel && penable;
  endsequence
  // Three samples cover the state edge plus the registered pin edge
  sequence float_s;
    sense_in.timer_pin_float [*3];
  endsequence
  sequence comp_high_s;
    (sense_in.mode_comparator && sense_in.sense_at_high) [*3];
  endsequence
  // ==========================================================================
  // Assertions
  pready_high_a: assert property (pready)
    else $error("pready low");
  err_unmapped_a: assert property (access_s and unmapped |-> pslverr)
    else $error("no error on unmapped access");
  err_only_a: assert property (pslverr |-> psel && penable && unmapped)
    else $error("spurious pslverr");
  rd_zero_a: assert property (access_s and !pwrite && unmapped |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  float_idle_a: assert property (float_s |-> !charge_drive_oe && !status_indicator_oe)
    else $error("pins not released while suspended");
  float_ref_a: assert property (float_s |-> ref_topoff)
    else $error("fast reference outside fast charge");
  comp_off_a: assert property (comp_high_s |-> !charge_drive_oe)
    else $error("drive on above high threshold");
  lin_start_a: assert property ($rose(charge_drive_oe) && !sense_in.mode_comparator
    |-> $past(window) || $past(window, 2) || $past(window, 3))
    else $error("charge started outside window");
  od_pins_a: assert property (!charge_drive_out && !status_indicator_out)
    else $error("open-drain pin driven high");
endmodule : nct_charge_seq_chk

bind nct_charge_seq nct_charge_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sense_in(sense_in), .thm_code(thm_code), .ref_topoff(ref_topoff),
  .charge_drive_out(charge_drive_out), .charge_drive_oe(charge_drive_oe),
  .status_indicator_out(status_indicator_out), .status_indicator_oe(status_indicator_oe));

// ### nct_pack_model.sv
// Behavioural cell pack: cell voltage, sense ramp and thermistor
`timescale 1ns/1ps

module nct_pack_model (
  // Clock and charge drive level
  input wire logic            clk,
  input wire logic            drive_on,
  // Scenario controls
  input wire logic            temp_ok,
  input wire logic            hot,
  input wire logic            removed,
  input wire logic            dead,
  input wire logic            heat,
  input wire logic            float_pin,
  input wire logic            comp,
  // Front-end results
  output nct_pkg::nct_sense_s sense,
  output logic [9:0]          thermistor_sense_in
);
  import nct_pkg::*;
  logic [3:0] cell_reg = 4'h0;
  logic [2:0] cur_reg = 3'h0;
  logic [5:0] div_reg = 6'h00;
  initial thermistor_sense_in = 10'h320;
  // Current ramps while drive is on, so the comparator really switches
  always @(posedge clk) begin
    div_reg <= div_reg + 6'h01;
    if (drive_on && cell_reg != 4'hF) cell_reg <= cell_reg + 4'h1;
    if (drive_on && cur_reg != 3'h7) cur_reg <= cur_reg + 3'h1;
    else if (!drive_on && cur_reg != 3'h0) cur_reg <= cur_reg - 3'h1;
    if (!heat) thermistor_sense_in <= 10'h320;
    else if (div_reg == 6'h00) thermistor_sense_in <= thermistor_sense_in - 10'h001;
  end
  // All results are single bits synchronous to clk
  assign sense = {cur_reg <= 3'h1, cur_reg >= 3'h6, temp_ok, temp_ok, hot,
                  cell_reg >= 4'h8 && !dead, removed, float_pin, comp};
endmodule : nct_pack_model

// ### tb_nimh_charge_timer_thermal_fsm.sv
// Self-checking testbench for the charge-phase sequencer
`timescale 1ns/1ps
`include "nct_cfg.svh"
`define CHK(a, b) chk_val(32'(a), 32'(b))

module tb_nimh_charge_timer_thermal_fsm;
  import nct_pkg::*;
  localparam int TC = 4;
  logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, ref_topoff, drv_out, drv_oe, ind_out, ind_oe, drive_on;
  logic        temp_ok = 1'b0, hot = 1'b0, removed = 1'b0, dead = 1'b0, heat = 1'b0;
  logic        float_pin = 1'b0, comp = 1'b0;
  nct_sense_s  sense;
  logic [9:0]  thermistor_sense_in;
  int          num_errors = 0, compares = 0, cyc = 0, t0 = 0, n;
  assign drive_on = !(drv_oe ? drv_out : 1'b1);
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  nct_charge_seq #(.TICK_CYCLES(TC)) dut_u (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_in(sense), .thm_code(thermistor_sense_in), .ref_topoff(ref_topoff),
    .charge_drive_out(drv_out), .charge_drive_oe(drv_oe),
    .status_indicator_out(ind_out), .status_indicator_oe(ind_oe));
  nct_pack_model pack_u (
    .clk(clk), .drive_on(drive_on), .temp_ok(temp_ok), .hot(hot), .removed(removed),
    .dead(dead), .heat(heat), .float_pin(float_pin), .comp(comp), .sense(sense), .thermistor_sense_in(thermistor_sense_in));
  // ==========================================================================
  // Tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  // One idle cycle after each transfer keeps psel from being set twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e);
  endtask : rd_chk
  task automatic st(input logic [5:0] e);
    apb(1'b0, `NCT_STATUS_OFFS, 32'h0000_0000);
    `CHK(rd[5:0], e);
  endtask : st
  task automatic wait_st(input logic [5:0] e);
    int i;
    i = 0;
    do begin
      apb(1'b0, `NCT_STATUS_OFFS, 32'h0000_0000);
      i++;
    end while (rd[5:0] !== e && i < 3000);
    t0 = cyc;
    `CHK(rd[5:0], e);
  endtask : wait_st
  task automatic wait_until(input int t);
    while (cyc < t0 + t * TC) @(posedge clk);
  endtask : wait_until
  // Tick phase is free running, so expiry is bracketed by three ticks each side
  task automatic span(input logic [5:0] b, input logic [5:0] a, input int t);
    wait_until(t - 3);
    st(b);
    wait_until(t + 3);
    st(a);
  endtask : span
  task automatic blink(input int h);
    logic p;
    p = ind_oe;
    for (n = 0; n < 64 && ind_oe === p; n++) @(posedge clk);
    p = ind_oe;
    for (n = 0; n < 64 && ind_oe === p; n++) @(posedge clk);
    `CHK(n, h * TC);
  endtask : blink
  task automatic unplug();
    temp_ok <= 1'b0;
    removed <= 1'b1;
    wait_st(NCT_IDLE);
    removed <= 1'b0;
  endtask : unplug
  task automatic finish_test();
    $display("Counts: compares %0d, num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================================================
  // Tests
  initial begin
    // Precharge dominates; the whole sequence needs about 80k cycles
    repeat (90000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk(`NCT_STATUS_OFFS, 32'h0000_0001);
    rd_chk(`NCT_CTRL_OFFS, 32'(`NCT_KOHM_RESET));
    rd_chk(`NCT_TIMER_OFFS, 32'h0000_0000);
    apb(1'b1, `NCT_STATUS_OFFS, 32'hFFFF_FFFF);
    rd_chk(`NCT_STATUS_OFFS, 32'h0000_0001);
    rd_chk(12'h00C, 32'h0000_0000);
    `CHK(err, 1'b1);
    $display("Test registers done");
    dead <= 1'b1;
    repeat (40) @(posedge clk);
    st(NCT_IDLE);
    temp_ok <= 1'b1;
    wait_st(NCT_PRECHARGE);
    span(NCT_PRECHARGE, NCT_FAULT, `NCT_PRECHARGE_TICKS);
    `CHK(rd[8], 1'b0);
    blink(1);
    unplug();
    temp_ok <= 1'b1;
    wait_st(NCT_PRECHARGE);
    hot <= 1'b1;
    wait_st(NCT_FAULT);
    hot <= 1'b0;
    unplug();
    $display("Test precharge done");
    dead <= 1'b0;
    for (int q = 0; q < 2; q++) begin
      apb(1'b1, `NCT_CTRL_OFFS, {23'h0, q[0], 8'h01});
      temp_ok <= 1'b1;
      wait_st(NCT_FAST);
      `CHK(rd[8], 1'b1);
      `CHK(ref_topoff, 1'b0);
      blink(4);
      span(NCT_FAST, NCT_TOPOFF, `NCT_TICKS_PER_KOHM);
      apb(1'b0, `NCT_TIMER_OFFS, 32'h0000_0000);
      `CHK(rd < 32'd12, 1'b1);
      t0 = cyc - int'(rd) * TC;
      `CHK(ref_topoff, 1'b1);
      span(NCT_TOPOFF, NCT_DONE, `NCT_TICKS_PER_KOHM >> (q + 1));
      `CHK(rd[9:8], 2'b00);
      unplug();
    end
    $display("Test timeouts done");
    apb(1'b1, `NCT_CTRL_OFFS, 32'h0000_0005);
    heat <= 1'b1;
    temp_ok <= 1'b1;
    wait_st(NCT_FAST);
    wait_until(`NCT_BLANK_TICKS - 8);
    st(NCT_FAST);
    `CHK(rd[11:10], 2'b00);
    // Armed but no trip yet: the detector needs two minute samples
    wait_until(`NCT_BLANK_TICKS + 8);
    st(NCT_FAST);
    `CHK(rd[11:10], 2'b10);
    wait_until(`NCT_BLANK_TICKS + 2 * `NCT_TICKS_PER_MIN + 8);
    st(NCT_TOPOFF);
    heat <= 1'b0;
    hot <= 1'b1;
    wait_st(NCT_DONE);
    hot <= 1'b0;
    unplug();
    $display("Test rate done");
    comp <= 1'b1;
    temp_ok <= 1'b1;
    wait_st(NCT_FAST);
    n = 0;
    repeat (200) begin
      err = drv_oe;
      @(posedge clk);
      if (drv_oe !== err) n++;
    end
    `CHK(n > 3, 1'b1);
    float_pin <= 1'b1;
    wait_st(NCT_IDLE);
    rd_chk(`NCT_TIMER_OFFS, 32'h0000_0000);
    repeat (20) @(posedge clk);
    st(NCT_IDLE);
    float_pin <= 1'b0;
    $display("Test comparator done");
    finish_test();
  end
endmodule : tb_nimh_charge_timer_thermal_fsm
